// file: dual_current_output_scaler_regs.vh
// register offsets, field layouts and reset values for the dual current output scaler
`ifndef DUAL_CURRENT_OUTPUT_SCALER_REGS_VH
`define DUAL_CURRENT_OUTPUT_SCALER_REGS_VH
`define ADDR_W               4
`define DATA_W               16
`define REG_PRIMARY_SELECT   4'h0
`define REG_PRIMARY_ZERO     4'h1
`define REG_PRIMARY_FULL     4'h2
`define REG_ROUTING_MODE     4'h3
`define REG_SECONDARY_SELECT 4'h4
`define REG_SECONDARY_ZERO   4'h5
`define REG_SECONDARY_FULL   4'h6
`define REG_BIAS_TRIM_A      4'h7
`define REG_BIAS_TRIM_B      4'h8
`define REG_CONTROL          4'h9
`define REG_STATUS           4'ha
`define REG_LEVEL_A          4'hb
`define REG_LEVEL_B          4'hc
`define SEL_W                8
`define SEL_RESET            8'h02
`define SEL_REFERENCE        8'h15
`define PCT_W                11
`define PCT_ZERO_RESET       11'h000
`define PCT_FULL_RESET       11'h3e8
`define PCT_MAX              11'h3e8
`define TRIM_W               11
`define TRIM_MIN             11'h384
`define TRIM_MAX             11'h44c
`define TRIM_RESET           11'h3e8
`define MODE_W               4
`define MODE_SAME            4'h0
`define MODE_SPLIT           4'h1
`define MODE_SAME_ALT        4'ha
`define MODE_SPLIT_ALT       4'hb
`define MODE_RESET           4'h0
`define LEVEL_W              16
`define LEVEL_4MA            16'h3333
`define LEVEL_20MA           16'hffff
`define LEVEL_SPAN           16'hcccc
`define LEVEL_OFF            16'h0000
`define CTRL_FAULT_CLR_BIT   0
`define CTRL_COMPANION_BIT   1
`define STAT_FAULT_BIT       0
`define STAT_SPLIT_BIT       1
`define STAT_HOLD_A_BIT      2
`define STAT_HOLD_B_BIT      3
`define STAT_REF_BIT         4
`define STAT_BUSY_BIT        5
`endif

// file: monitor_selector.v
// picks one monitor value by its selection code
`timescale 1ns/1ps
`include "dual_current_output_scaler_regs.vh"
module monitor_selector #(
  parameter NUM_MON = 32
) (
  input  wire                           sys_clk,
  input  wire                           sys_rst,
  input  wire [`SEL_W-1:0]              sel_code,
  input  wire [NUM_MON*`PCT_W-1:0]      monitor_bus,
  output reg  [`PCT_W-1:0]              value_r
);
  // unknown codes give zero signal rather than a stale one
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      value_r <= {`PCT_W{1'b0}};
    end else if (sel_code < NUM_MON) begin
      value_r <= monitor_bus[sel_code*`PCT_W +: `PCT_W];
    end else begin
      value_r <= {`PCT_W{1'b0}};
    end
  end
endmodule // monitor_selector

// file: span_scaler.v
// maps one monitor value onto the 4 to 20 ma code span
`timescale 1ns/1ps
`include "dual_current_output_scaler_regs.vh"
module span_scaler (
  input  wire                  sys_clk,
  input  wire                  sys_rst,
  input  wire [`PCT_W-1:0]     value,
  input  wire [`PCT_W-1:0]     zero_pt,
  input  wire [`PCT_W-1:0]     full_pt,
  input  wire [`TRIM_W-1:0]    bias_trim,
  output reg  [`LEVEL_W-1:0]   level_r,
  output reg                   hold_r
);
  reg  [`LEVEL_W-1:0] level_nxt;
  reg  [31:0]         num;
  reg  [31:0]         quo;
  reg  [31:0]         bias;
  wire                degenerate = (zero_pt >= full_pt);
  // combinational divide trades area for a fixed one-cycle latency
  always @* begin
    bias = (`LEVEL_4MA * bias_trim) / `TRIM_RESET;
    num  = 32'h0;
    quo  = 32'h0;
    if (degenerate) begin
      level_nxt = bias[`LEVEL_W-1:0];
    end else if (value <= zero_pt) begin
      level_nxt = bias[`LEVEL_W-1:0];
    end else if (value >= full_pt) begin
      level_nxt = `LEVEL_20MA;
    end else begin
      num = (value - zero_pt) * (`LEVEL_20MA - bias);
      quo = num / (full_pt - zero_pt);
      level_nxt = bias[`LEVEL_W-1:0] + quo[`LEVEL_W-1:0];
    end
  end
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      level_r <= `LEVEL_OFF;
      hold_r  <= 1'b0;
    end else begin
      level_r <= level_nxt;
      hold_r  <= degenerate;
    end
  end
endmodule // span_scaler

// file: dual_current_output_scaler.v
// parameter store, routing and trip shutoff for two 4 to 20 ma outputs
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "dual_current_output_scaler_regs.vh"
module dual_current_output_scaler #(
  parameter NUM_MON = 32
) (
  input  wire                      sys_clk,
  input  wire                      sys_rst,
  input  wire [`ADDR_W-1:0]        reg_addr,
  input  wire [`DATA_W-1:0]        reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [`DATA_W-1:0]        reg_rdata_r,
  input  wire [NUM_MON*`PCT_W-1:0] monitor_bus,
  input  wire                      drive_running,
  input  wire                      option_fault,
  input  wire                      companion_fitted,
  output reg  [`LEVEL_W-1:0]       current_out_a_r,
  output reg  [`LEVEL_W-1:0]       current_out_b_r,
  output reg                       analog_priority_r
);
  reg  [`SEL_W-1:0]   primary_signal_select_r;
  reg  [`PCT_W-1:0]   primary_zero_point_r;
  reg  [`PCT_W-1:0]   primary_full_point_r;
  reg  [`MODE_W-1:0]  output_routing_mode_r;
  reg  [`SEL_W-1:0]   secondary_signal_select_r;
  reg  [`PCT_W-1:0]   secondary_zero_point_r;
  reg  [`PCT_W-1:0]   secondary_full_point_r;
  reg  [`TRIM_W-1:0]  bias_trim_a_r;
  reg  [`TRIM_W-1:0]  bias_trim_b_r;
  reg                 fault_r;
  reg                 fault_s1_r;
  reg                 fault_s2_r;
  reg                 comp_s1_r;
  reg                 comp_s2_r;
  reg                 run_s1_r;
  reg                 run_s2_r;
  reg  [`DATA_W-1:0]  rdata_nxt;
  wire                split;
  wire [`SEL_W-1:0]   sel_a;
  wire [`PCT_W-1:0]   zero_a;
  wire [`PCT_W-1:0]   full_a;
  wire [`PCT_W-1:0]   val_a;
  wire [`PCT_W-1:0]   val_b;
  wire [`LEVEL_W-1:0] lvl_a;
  wire [`LEVEL_W-1:0] lvl_b;
  wire                hold_a;
  wire                hold_b;
  wire                wr_primary_select;
  wire                wr_primary_zero;
  wire                wr_primary_full;
  wire                wr_routing_mode;
  wire                wr_secondary_select;
  wire                wr_secondary_zero;
  wire                wr_secondary_full;
  wire                wr_trim_a;
  wire                wr_trim_b;
  wire                wr_control;
  wire                out_cut;
  wire                ref_ready;

  function mode_ok;
    input [`MODE_W-1:0] m;
    begin
      mode_ok = (m == `MODE_SAME) || (m == `MODE_SPLIT) ||
                (m == `MODE_SAME_ALT) || (m == `MODE_SPLIT_ALT);
    end
  endfunction

  function pct_ok;
    input [`DATA_W-1:0] d;
    begin
      pct_ok = (d <= `PCT_MAX);
    end
  endfunction

  function trim_ok;
    input [`DATA_W-1:0] d;
    begin
      trim_ok = (d >= `TRIM_MIN) && (d <= `TRIM_MAX);
    end
  endfunction

  // upper bits must be clear too, so a wide value cannot alias a legal mode
  function mode_word_ok;
    input [`DATA_W-1:0] d;
    begin
      mode_word_ok = mode_ok(d[`MODE_W-1:0]) && (d[`DATA_W-1:`MODE_W] == {(`DATA_W-`MODE_W){1'b0}});
    end
  endfunction

  // 0 and 10, and 1 and 11, differ only in bits 1 and 3, so bit 0 alone chooses the routing
  assign split  = output_routing_mode_r[0];
  assign sel_a  = split ? secondary_signal_select_r : primary_signal_select_r;
  assign zero_a = split ? secondary_zero_point_r : primary_zero_point_r;
  assign full_a = split ? secondary_full_point_r : primary_full_point_r;

  // one strobe per register so each store keeps its own block
  assign wr_primary_select   = reg_wr && (reg_addr == `REG_PRIMARY_SELECT);
  assign wr_primary_zero     = reg_wr && (reg_addr == `REG_PRIMARY_ZERO);
  assign wr_primary_full     = reg_wr && (reg_addr == `REG_PRIMARY_FULL);
  assign wr_routing_mode     = reg_wr && (reg_addr == `REG_ROUTING_MODE);
  assign wr_secondary_select = reg_wr && (reg_addr == `REG_SECONDARY_SELECT);
  assign wr_secondary_zero   = reg_wr && (reg_addr == `REG_SECONDARY_ZERO);
  assign wr_secondary_full   = reg_wr && (reg_addr == `REG_SECONDARY_FULL);
  assign wr_trim_a           = reg_wr && (reg_addr == `REG_BIAS_TRIM_A);
  assign wr_trim_b           = reg_wr && (reg_addr == `REG_BIAS_TRIM_B);
  assign wr_control          = reg_wr && (reg_addr == `REG_CONTROL);

  // the raw synchronised trip also cuts outputs without waiting for fault_r
  assign out_cut   = fault_r || fault_s2_r;
  // reference code in every selection in use, as calibration expects
  assign ref_ready = (primary_signal_select_r == `SEL_REFERENCE) &&
                     (!split || secondary_signal_select_r == `SEL_REFERENCE);

  // pins cross two flops before use
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      fault_s1_r <= 1'b0;
      fault_s2_r <= 1'b0;
    end else begin
      fault_s1_r <= option_fault;
      fault_s2_r <= fault_s1_r;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      comp_s1_r <= 1'b0;
      comp_s2_r <= 1'b0;
    end else begin
      comp_s1_r <= companion_fitted;
      comp_s2_r <= comp_s1_r;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      run_s1_r <= 1'b0;
      run_s2_r <= 1'b0;
    end else begin
      run_s1_r <= drive_running;
      run_s2_r <= run_s1_r;
    end
  end

  // parameter writes; out-of-range points, trims and modes are dropped, old value kept; selects take any code
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      primary_signal_select_r <= `SEL_RESET;
    end else if (wr_primary_select) begin
      primary_signal_select_r <= reg_wdata[`SEL_W-1:0];
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      primary_zero_point_r <= `PCT_ZERO_RESET;
    end else if (wr_primary_zero && pct_ok(reg_wdata)) begin
      primary_zero_point_r <= reg_wdata[`PCT_W-1:0];
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      primary_full_point_r <= `PCT_FULL_RESET;
    end else if (wr_primary_full && pct_ok(reg_wdata)) begin
      primary_full_point_r <= reg_wdata[`PCT_W-1:0];
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      output_routing_mode_r <= `MODE_RESET;
    end else if (wr_routing_mode && mode_word_ok(reg_wdata)) begin
      output_routing_mode_r <= reg_wdata[`MODE_W-1:0];
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      secondary_signal_select_r <= `SEL_RESET;
    end else if (wr_secondary_select) begin
      secondary_signal_select_r <= reg_wdata[`SEL_W-1:0];
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      secondary_zero_point_r <= `PCT_ZERO_RESET;
    end else if (wr_secondary_zero && pct_ok(reg_wdata)) begin
      secondary_zero_point_r <= reg_wdata[`PCT_W-1:0];
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      secondary_full_point_r <= `PCT_FULL_RESET;
    end else if (wr_secondary_full && pct_ok(reg_wdata)) begin
      secondary_full_point_r <= reg_wdata[`PCT_W-1:0];
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      bias_trim_a_r <= `TRIM_RESET;
    end else if (wr_trim_a && trim_ok(reg_wdata)) begin
      bias_trim_a_r <= reg_wdata[`TRIM_W-1:0];
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      bias_trim_b_r <= `TRIM_RESET;
    end else if (wr_trim_b && trim_ok(reg_wdata)) begin
      bias_trim_b_r <= reg_wdata[`TRIM_W-1:0];
    end
  end

  // trip is sticky; a new trip in the clear cycle wins over the clear
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      fault_r <= 1'b0;
    end else if (fault_s2_r) begin
      fault_r <= 1'b1;
    end else if (wr_control && reg_wdata[`CTRL_FAULT_CLR_BIT]) begin
      fault_r <= 1'b0;
    end
  end

  monitor_selector #(
    .NUM_MON (NUM_MON)
  ) u_sel_a (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .sel_code    (sel_a),
    .monitor_bus (monitor_bus),
    .value_r     (val_a)
  );

  monitor_selector #(
    .NUM_MON (NUM_MON)
  ) u_sel_b (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .sel_code    (primary_signal_select_r),
    .monitor_bus (monitor_bus),
    .value_r     (val_b)
  );

  span_scaler u_scale_a (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .value     (val_a),
    .zero_pt   (zero_a),
    .full_pt   (full_a),
    .bias_trim (bias_trim_a_r),
    .level_r   (lvl_a),
    .hold_r    (hold_a)
  );

  span_scaler u_scale_b (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .value     (val_b),
    .zero_pt   (primary_zero_point_r),
    .full_pt   (primary_full_point_r),
    .bias_trim (bias_trim_b_r),
    .level_r   (lvl_b),
    .hold_r    (hold_b)
  );

  // level outputs register off the scalers, zeroed while out_cut is set; the priority flag registers off comp_s2_r
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      current_out_a_r <= `LEVEL_OFF;
    end else begin
      current_out_a_r <= out_cut ? `LEVEL_OFF : lvl_a;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      current_out_b_r <= `LEVEL_OFF;
    end else begin
      current_out_b_r <= out_cut ? `LEVEL_OFF : lvl_b;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      analog_priority_r <= 1'b0;
    end else begin
      analog_priority_r <= comp_s2_r;
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    rdata_nxt = {`DATA_W{1'b0}};
    case (reg_addr)
      `REG_PRIMARY_SELECT:   rdata_nxt[`SEL_W-1:0]  = primary_signal_select_r;
      `REG_PRIMARY_ZERO:     rdata_nxt[`PCT_W-1:0]  = primary_zero_point_r;
      `REG_PRIMARY_FULL:     rdata_nxt[`PCT_W-1:0]  = primary_full_point_r;
      `REG_ROUTING_MODE:     rdata_nxt[`MODE_W-1:0] = output_routing_mode_r;
      `REG_SECONDARY_SELECT: rdata_nxt[`SEL_W-1:0]  = secondary_signal_select_r;
      `REG_SECONDARY_ZERO:   rdata_nxt[`PCT_W-1:0]  = secondary_zero_point_r;
      `REG_SECONDARY_FULL:   rdata_nxt[`PCT_W-1:0]  = secondary_full_point_r;
      `REG_BIAS_TRIM_A:      rdata_nxt[`TRIM_W-1:0] = bias_trim_a_r;
      `REG_BIAS_TRIM_B:      rdata_nxt[`TRIM_W-1:0] = bias_trim_b_r;
      `REG_CONTROL:          rdata_nxt[`CTRL_COMPANION_BIT] = comp_s2_r;
      `REG_STATUS: begin
        rdata_nxt[`STAT_FAULT_BIT]  = fault_r;
        rdata_nxt[`STAT_SPLIT_BIT]  = split;
        rdata_nxt[`STAT_HOLD_A_BIT] = hold_a;
        rdata_nxt[`STAT_HOLD_B_BIT] = hold_b;
        rdata_nxt[`STAT_REF_BIT]    = ref_ready;
        rdata_nxt[`STAT_BUSY_BIT]   = run_s2_r;
      end
      `REG_LEVEL_A:          rdata_nxt = current_out_a_r;
      `REG_LEVEL_B:          rdata_nxt = current_out_b_r;
      default:               rdata_nxt = {`DATA_W{1'b0}};
    endcase
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata_r <= {`DATA_W{1'b0}};
    end else if (reg_rd) begin
      reg_rdata_r <= rdata_nxt;
    end else begin
      reg_rdata_r <= {`DATA_W{1'b0}};
    end
  end
endmodule // dual_current_output_scaler

// file: scaler_checker_assertions.sv
// port checker for the dual current output scaler
`timescale 1ns/1ps
`include "dual_current_output_scaler_regs.vh"
module scaler_checker (
  input wire                sys_clk,
  input wire                sys_rst,
  input wire [`ADDR_W-1:0]  reg_addr,
  input wire                reg_rd,
  input wire [`DATA_W-1:0]  reg_rdata_r,
  input wire                option_fault,
  input wire                companion_fitted,
  input wire [`LEVEL_W-1:0] current_out_a_r,
  input wire [`LEVEL_W-1:0] current_out_b_r,
  input wire                analog_priority_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata_r == 16'h0000)
    else $error("read data not cleared");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 4'hc |=> reg_rdata_r == 16'h0000)
    else $error("unmapped read not zero");
  a_mode_legal: assert property (reg_rd && reg_addr == `REG_ROUTING_MODE |=>
    reg_rdata_r inside {16'h0000, 16'h0001, 16'h000a, 16'h000b}) else $error("illegal mode held");
  a_pct_range: assert property (reg_rd && reg_addr inside {4'h1, 4'h2, 4'h5, 4'h6} |=>
    reg_rdata_r <= 16'h03e8) else $error("point above full scale");
  a_trim_range: assert property (reg_rd && reg_addr inside {4'h7, 4'h8} |=>
    reg_rdata_r inside {[16'h0384:16'h044c]}) else $error("trim out of range");
  a_sel_width: assert property (reg_rd && reg_addr inside {4'h0, 4'h4} |=>
    reg_rdata_r[15:8] == 8'h00) else $error("select wider than code");
  // two sync flops plus the output register
  a_fault_off: assert property (option_fault [*3] |=>
    current_out_a_r == 16'h0000 && current_out_b_r == 16'h0000) else $error("outputs live in trip");
  a_companion_on: assert property (companion_fitted [*4] |-> analog_priority_r)
    else $error("priority flag missing");
  a_companion_off: assert property (!companion_fitted [*4] |-> !analog_priority_r)
    else $error("priority flag stuck");
  // lowest live code is the bias at minimum trim
  a_floor_a: assert property (current_out_a_r == 16'h0000 || current_out_a_r >= 16'h2e14)
    else $error("output a below span");
  cover property (option_fault [*3]);
  cover property (companion_fitted [*4]);
  cover property (reg_rd && reg_addr == `REG_ROUTING_MODE);
endmodule // scaler_checker
bind dual_current_output_scaler scaler_checker chk_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata_r(reg_rdata_r), .option_fault(option_fault), .companion_fitted(companion_fitted),
  .current_out_a_r(current_out_a_r), .current_out_b_r(current_out_b_r),
  .analog_priority_r(analog_priority_r));

// file: monitor_source.sv
// host drive model feeding monitor values by selection code
`timescale 1ns/1ps
`include "dual_current_output_scaler_regs.vh"
module monitor_source #(
  parameter NUM_MON = 32
) (
  input  wire  [`PCT_W-1:0]         shift,
  output logic [NUM_MON*`PCT_W-1:0] monitor_bus
);
  // every slot distinct so a wrong select shows
  always_comb begin
    for (int n = 0; n < NUM_MON; n++) begin
      monitor_bus[n*`PCT_W +: `PCT_W] = `PCT_W'((n * 30 + shift) % 1001);
    end
  end
endmodule // monitor_source

// file: dual_current_output_scaler_test.sv
// self-checking bench for the dual current output scaler
`timescale 1ns/1ps
`include "dual_current_output_scaler_regs.vh"
module dual_current_output_scaler_test;
  logic                 sys_clk = 1'b0;
  logic                 sys_rst = 1'b1;
  logic [`ADDR_W-1:0]   reg_addr = 4'h0;
  logic [`DATA_W-1:0]   reg_wdata = 16'h0000;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic                 drive_running = 1'b0;
  logic                 option_fault = 1'b0;
  logic                 companion_fitted = 1'b0;
  logic [`PCT_W-1:0]    shift = 11'h007;
  logic [`DATA_W-1:0]   rdv;
  wire  [`DATA_W-1:0]   reg_rdata_r;
  wire  [32*`PCT_W-1:0] monitor_bus;
  wire  [`LEVEL_W-1:0]  out_a;
  wire  [`LEVEL_W-1:0]  out_b;
  wire                  prio;
  int                   err_count = 0;
  int                   comparisons = 0;
  // address, write data, value read back; refused writes keep the old value
  logic [35:0] rows [16] = '{
    {4'h3, 16'h0002, 16'h0000}, {4'h3, 16'h000a, 16'h000a}, {4'h3, 16'h0005, 16'h000a}, {4'h3, 16'h000b, 16'h000b},
    {4'h3, 16'h0010, 16'h000b}, {4'h3, 16'h0001, 16'h0001}, {4'h3, 16'h0000, 16'h0000}, {4'h1, 16'h03e9, 16'h0000},
    {4'h1, 16'h03e8, 16'h03e8}, {4'h6, 16'h03e9, 16'h03e8}, {4'h7, 16'h0383, 16'h03e8}, {4'h7, 16'h044c, 16'h044c},
    {4'h7, 16'h044d, 16'h044c}, {4'h8, 16'h0384, 16'h0384}, {4'h4, 16'h00ff, 16'h00ff}, {4'hd, 16'h1234, 16'h0000}};
  logic [15:0] rst_vals [9] = '{16'h0002, 16'h0000, 16'h03e8, 16'h0000, 16'h0002, 16'h0000, 16'h03e8, 16'h03e8,
    16'h03e8};
  always #2 sys_clk = ~sys_clk;
  monitor_source #(.NUM_MON(32)) host (.shift(shift), .monitor_bus(monitor_bus));
  dual_current_output_scaler #(.NUM_MON(32)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .monitor_bus(monitor_bus), .drive_running(drive_running),
    .option_fault(option_fault), .companion_fitted(companion_fitted), .current_out_a_r(out_a),
    .current_out_b_r(out_b), .analog_priority_r(prio));
  function automatic int mon(int n);
    return (n * 30 + shift) % 1001;
  endfunction
  function automatic logic [15:0] lvl(int v, int z, int f, int t);
    int b;
    b = `LEVEL_4MA * t / 1000;
    if (z >= f || v <= z) return 16'(b);
    if (v >= f) return `LEVEL_20MA;
    return 16'(b + (v - z) * (`LEVEL_20MA - b) / (f - z));
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata_r;
  endtask
  // outputs lag a change by three registers
  task automatic settle;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i][35:32], rows[i][31:16]);
      rd(rows[i][35:32]);
      chk("row", rdv, rows[i][15:0]);
    end
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 9; a++) begin
      rd(4'(a));
      chk("reset", rdv, rst_vals[a]);
    end
    wr(`REG_PRIMARY_SELECT, 16'h000a);
    wr(`REG_PRIMARY_ZERO, 16'h0064);
    wr(`REG_PRIMARY_FULL, 16'h0320);
    wr(`REG_SECONDARY_SELECT, 16'h0005);
    settle();
    chk("same a", out_a, lvl(mon(10), 100, 800, 1000));
    chk("same b", out_b, lvl(mon(10), 100, 800, 1000));
    wr(`REG_ROUTING_MODE, 16'h000b);
    wr(`REG_SECONDARY_SELECT, 16'h0014);
    wr(`REG_SECONDARY_FULL, 16'h01f4);
    settle();
    chk("split a", out_a, lvl(mon(20), 0, 500, 1000));
    chk("split b", out_b, lvl(mon(10), 100, 800, 1000));
    wr(`REG_BIAS_TRIM_A, 16'h03b6);
    wr(`REG_SECONDARY_ZERO, 16'h01f4);
    settle();
    chk("hold a", out_a, lvl(0, 500, 500, 950));
    @(posedge sys_clk);
    drive_running <= 1'b1;
    wr(`REG_PRIMARY_SELECT, {8'h00, `SEL_REFERENCE});
    wr(`REG_SECONDARY_SELECT, {8'h00, `SEL_REFERENCE});
    rd(`REG_PRIMARY_SELECT);
    chk("run sel", rdv, 16'h0015);
    rd(`REG_STATUS);
    chk("status", rdv, 16'h0036);
    @(posedge sys_clk);
    option_fault <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 chk("trip a", out_a, 16'h0000);
    chk("trip b", out_b, 16'h0000);
    @(posedge sys_clk);
    option_fault <= 1'b0;
    settle();
    chk("latched", out_b, 16'h0000);
    wr(`REG_CONTROL, 16'h0001);
    settle();
    chk("cleared", out_b, lvl(mon(21), 100, 800, 1000));
    @(posedge sys_clk);
    companion_fitted <= 1'b1;
    settle();
    chk("priority", {15'h0000, prio}, 16'h0001);
    rd(`REG_CONTROL);
    chk("companion", rdv, 16'h0002);
    wr(`REG_ROUTING_MODE, 16'h000a);
    settle();
    chk("alt a", out_a, lvl(mon(21), 100, 800, 950));
    chk("alt b", out_b, lvl(mon(21), 100, 800, 1000));
    tally_and_finish();
  end
endmodule // dual_current_output_scaler_test
